// ### design/core_pkg.sv
package core_pkg;

    // Widths
    localparam int PC_W    = 13;
    localparam int PM_AW   = 10;
    localparam int IW      = 14;
    localparam int DW      = 8;
    localparam int GPR_AW  = 6;
    localparam int GPR_DEPTH = 36;

    // Vectors and reset values
    localparam logic [PC_W-1:0] RESET_VECTOR  = 13'h0000;
    localparam logic [PC_W-1:0] INT_VECTOR    = 13'h0004;
    localparam logic [PC_W-1:0] PC_STEP       = 13'h0001;
    localparam logic [DW-1:0]   STATUS_RESET  = 8'h18;
    localparam logic [4:0]      PROG_COUNTER_HIGH_LATCH_RESET  = 5'h00;
    localparam logic [DW-1:0]   INTERRUPT_CONTROL_RESET  = 8'h00;
    localparam logic [DW-1:0]   ACC_RESET     = 8'h00;
    localparam logic [DW-1:0]   FSR_RESET     = 8'h00;

    // Register addresses, bank 0
    localparam logic [7:0] ADDR_INDIRECT_DATA_WINDOW = 8'h00;
    localparam logic [7:0] ADDR_TIMER_COUNT          = 8'h01;
    localparam logic [7:0] ADDR_PROG_COUNTER_LOW     = 8'h02;
    localparam logic [7:0] ADDR_CORE_STATUS_FLAGS    = 8'h03;
    localparam logic [7:0] ADDR_INDIRECT_POINTER     = 8'h04;
    localparam logic [7:0] ADDR_PORT_A_PINS          = 8'h05;
    localparam logic [7:0] ADDR_PORT_B_PINS          = 8'h06;
    localparam logic [7:0] ADDR_UNIMPLEMENTED        = 8'h07;
    localparam logic [7:0] ADDR_NVM_DATA             = 8'h08;
    localparam logic [7:0] ADDR_NVM_ADDRESS          = 8'h09;
    localparam logic [7:0] ADDR_PROG_COUNTER_HIGH_LATCH = 8'h0a;
    localparam logic [7:0] ADDR_INTERRUPT_CONTROL    = 8'h0b;
    // Register addresses, bank 1
    localparam logic [7:0] ADDR_TIMER_PRESCALE_OPTIONS = 8'h81;
    localparam logic [7:0] ADDR_PORT_A_DIRECTION     = 8'h85;
    localparam logic [7:0] ADDR_PORT_B_DIRECTION     = 8'h86;
    localparam logic [7:0] ADDR_NVM_CONTROL          = 8'h88;
    localparam logic [7:0] ADDR_NVM_UNLOCK_SEQUENCE  = 8'h89;

    // Bank layout
    localparam logic [6:0] GPR_FIRST = 7'h0c;
    localparam logic [6:0] GPR_LAST  = 7'h2f;

    // Status and interrupt control bits
    localparam int STAT_RP1 = 6;
    localparam int STAT_RP0 = 5;
    localparam int STAT_Z   = 2;
    localparam int INTERRUPT_CONTROL_GIE = 7;

    // Instruction encodings
    localparam logic [1:0] OPC_JUMP      = 2'b10;
    localparam logic [1:0] OPC_LITERAL   = 2'b11;
    localparam logic [5:0] OPC_TO_FILE   = 6'h00;
    localparam logic [5:0] OPC_FROM_FILE = 6'h08;

    // Phases, Gray coded along the cycle
    typedef enum logic [1:0] {
        PH_ONE   = 2'b00,
        PH_TWO   = 2'b01,
        PH_THREE = 2'b11,
        PH_FOUR  = 2'b10
    } phase_t;

    // Peripheral register file request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       re;
        logic       we;
    } data_req_t;

endpackage

// ### design/phase_gen.sv
`timescale 1ns/10ps
`default_nettype none
module phase_gen (
    // Clock, reset, enable
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       clk_en,
    // Phase outputs
    output logic [3:0]      phase_vec,
    output logic            rate_out
);
    import core_pkg::*;

    phase_t     state_ff;
    phase_t     nxt_state;
    logic [3:0] nxt_vec;
    logic [3:0] phase_ff;
    logic       rate_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_vec   = 4'h0;
        unique case (state_ff)
            PH_ONE: begin
                nxt_state = PH_TWO;
                nxt_vec   = 4'h2;
            end
            PH_TWO: begin
                nxt_state = PH_THREE;
                nxt_vec   = 4'h4;
            end
            PH_THREE: begin
                nxt_state = PH_FOUR;
                nxt_vec   = 4'h8;
            end
            PH_FOUR: begin
                nxt_state = PH_ONE;
                nxt_vec   = 4'h1;
            end
        endcase
    end

    // Reset parks in the fourth phase so release starts with the first
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= PH_FOUR;
            phase_ff <= 4'h0;
            rate_ff  <= 1'b0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            phase_ff <= nxt_vec;
            rate_ff  <= (nxt_state == PH_ONE) || (nxt_state == PH_TWO);
        end
    end

    assign phase_vec = phase_ff;
    assign rate_out  = rate_ff;
endmodule
`default_nettype wire

// ### design/gpr_ram.sv
`timescale 1ns/10ps
`default_nettype none
module gpr_ram (
    // Clock, reset, enable
    input  wire logic                           clk_sys,
    input  wire logic                           reset,
    input  wire logic                           clk_en,
    // Access
    input  wire logic                           rd_en,
    input  wire logic                           wr_en,
    input  wire logic [core_pkg::GPR_AW-1:0]    idx,
    input  wire logic [core_pkg::DW-1:0]        wr_data,
    output logic [core_pkg::DW-1:0]             rd_data
);
    import core_pkg::*;

    logic [DW-1:0] mem_ff [GPR_DEPTH];
    logic [DW-1:0] rd_data_ff;

    always_ff @(posedge clk_sys) begin
        if (clk_en && wr_en && (idx < GPR_AW'(GPR_DEPTH))) begin
            mem_ff[idx] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_data_ff <= '0;
        end else if (clk_en && rd_en) begin
            rd_data_ff <= (idx < GPR_AW'(GPR_DEPTH)) ? mem_ff[idx] : '0;
        end
    end

    assign rd_data = rd_data_ff;
endmodule
`default_nettype wire

// ### design/core_clock_pipeline_memmap.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Oscillator divided into four ordered phases
// - Instruction cycle is exactly four phases
// - Program counter advances in phase one
// - Fetched word captured in phase four
// - Fetch of next overlaps current execute
// - Latch in phase one, execute two-four
// - Operand read phase two, write phase four
// - Counter changes cost two cycles, flush
// - Separate program and data buses
// - Nonvolatile data only via address pointer
// - Thirteen-bit counter, 1K words exist
// - Addresses wrap on low ten bits
// - Reset vector 0000h, interrupt 0004h
// - Direct bank from low select bit
// - Twelve special registers, then RAM
// - Bank 1 RAM aliases bank 0
// - Indirect uses both bank bits
// - Indirect and unlock locations have no storage
// - Byte moves between accumulator and file
// - Rate output at quarter oscillator rate
// - Unimplemented locations read zero, ignore writes
module core_clock_pipeline_memmap (
    // Clock, reset, enable
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    input  wire logic                       clk_en,
    // Interrupt request pin
    input  wire logic                       int_req_pin,
    // Program memory
    output logic [core_pkg::PM_AW-1:0]      prog_addr,
    input  wire logic [core_pkg::IW-1:0]    prog_data,
    // Peripheral register file
    output var core_pkg::data_req_t         per_req,
    input  wire logic [core_pkg::DW-1:0]    per_rdata,
    // Timing and state
    output logic [3:0]                      phase_vec,
    output logic                            instr_rate_out,
    output logic [core_pkg::DW-1:0]         acc_value,
    output logic [core_pkg::PC_W-1:0]       pc_value
);
    import core_pkg::*;

    logic              ph_one;
    logic              ph_two;
    logic              ph_three;
    logic              ph_four;

    logic [2:0]        int_sync_ff;
    logic              int_lvl_ff;

    // Pipeline state
    logic [PC_W-1:0]   pc_ff;
    logic [PM_AW-1:0]  fetch_addr_ff;
    logic [IW-1:0]     fetch_buf_ff;
    logic              fetch_valid_ff;
    logic [IW-1:0]     ir_ff;
    logic              exec_valid_ff;

    // Core registers
    logic [DW-1:0]     acc_ff;
    logic [DW-1:0]     status_ff;
    logic [DW-1:0]     fsr_ff;
    logic [4:0]        prog_counter_high_latch_ff;
    logic [DW-1:0]     interrupt_control_ff;
    logic [DW-1:0]     operand_ff;
    data_req_t         per_req_ff;

    // Decode and execute
    logic              is_jump;
    logic              is_literal;
    logic              is_to_file;
    logic              is_from_file;
    logic              indirect;
    logic [6:0]        offset;
    logic [7:0]        full_addr;
    logic              sel_void;
    logic              sel_gpr;
    logic              sel_per;
    logic              per_offset;
    logic              sel_core;
    logic [GPR_AW-1:0] gpr_idx;
    logic [DW-1:0]     gpr_rdata;
    logic              gpr_rd_en;
    logic              gpr_wr_en;
    logic [DW-1:0]     core_rd;
    logic [DW-1:0]     operand_now;
    logic [DW-1:0]     result;
    logic              wr_file;
    logic              wr_acc;
    logic              wr_core;
    logic              pcl_write;
    logic              branch;
    logic              take_int;
    logic [PC_W-1:0]   branch_target;

    // Phase generator
    phase_gen u_phase (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .clk_en    (clk_en),
        .phase_vec (phase_vec),
        .rate_out  (instr_rate_out)
    );

    assign ph_one   = phase_vec[0];
    assign ph_two   = phase_vec[1];
    assign ph_three = phase_vec[2];
    assign ph_four  = phase_vec[3];

    // Interrupt pin is asynchronous
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            int_sync_ff <= 3'h0;
        end else if (clk_en) begin
            int_sync_ff <= {int_sync_ff[1:0], int_req_pin};
        end
    end

    // Only a level that two stages agree on is taken
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            int_lvl_ff <= 1'b0;
        end else if (clk_en && (int_sync_ff[1] == int_sync_ff[2])) begin
            int_lvl_ff <= int_sync_ff[2];
        end
    end

    // Instruction class decode
    always_comb begin
        is_jump      = exec_valid_ff && (ir_ff[13:12] == OPC_JUMP);
        is_literal   = exec_valid_ff && (ir_ff[13:12] == OPC_LITERAL);
        is_to_file   = exec_valid_ff && (ir_ff[13:8] == OPC_TO_FILE) && ir_ff[7];
        is_from_file = exec_valid_ff && (ir_ff[13:8] == OPC_FROM_FILE);
    end

    // Data address decode
    always_comb begin
        indirect  = (ir_ff[6:0] == ADDR_INDIRECT_DATA_WINDOW[6:0]);
        offset    = indirect ? fsr_ff[6:0] : ir_ff[6:0];
        full_addr = {status_ff[STAT_RP0], offset};
        // Banks above the second do not exist
        sel_void  = (indirect && status_ff[STAT_RP1])
                    || (offset == ADDR_INDIRECT_DATA_WINDOW[6:0])
                    || (offset == ADDR_UNIMPLEMENTED[6:0])
                    || (offset > GPR_LAST);
        sel_gpr   = !sel_void && (offset >= GPR_FIRST);
        sel_per   = !sel_void && !sel_gpr && per_offset;
        sel_core  = !sel_void && !sel_gpr && !sel_per;
        // Bank bit dropped so both banks share one RAM
        gpr_idx   = GPR_AW'(offset - GPR_FIRST);
    end

    // Offsets served by the peripheral register file
    always_comb begin
        per_offset = (offset == ADDR_TIMER_COUNT[6:0])
                     || (offset == ADDR_PORT_A_PINS[6:0])
                     || (offset == ADDR_PORT_B_PINS[6:0])
                     || (offset == ADDR_NVM_DATA[6:0])
                     || (offset == ADDR_NVM_ADDRESS[6:0]);
    end

    // Core register read mux
    always_comb begin
        core_rd = 8'h00;
        unique case (offset)
            ADDR_PROG_COUNTER_LOW[6:0]:        core_rd = pc_ff[7:0];
            ADDR_CORE_STATUS_FLAGS[6:0]:       core_rd = status_ff;
            ADDR_INDIRECT_POINTER[6:0]:        core_rd = fsr_ff;
            ADDR_PROG_COUNTER_HIGH_LATCH[6:0]: core_rd = {3'h0, prog_counter_high_latch_ff};
            ADDR_INTERRUPT_CONTROL[6:0]:       core_rd = interrupt_control_ff;
            default:                           core_rd = 8'h00;
        endcase
    end

    // Operand source, valid in the third phase
    // Unlock location has no storage and reads as zero
    always_comb begin
        operand_now = 8'h00;
        if (sel_gpr) begin
            operand_now = gpr_rdata;
        end else if (sel_per && (full_addr != ADDR_NVM_UNLOCK_SEQUENCE)) begin
            operand_now = per_rdata;
        end else if (sel_core) begin
            operand_now = core_rd;
        end
    end

    // Execute decisions, acted on in the fourth phase
    always_comb begin
        result        = is_to_file ? acc_ff : operand_ff;
        wr_file       = (is_to_file || (is_from_file && ir_ff[7])) && !sel_void;
        wr_acc        = (is_from_file && !ir_ff[7]) || is_literal;
        wr_core       = wr_file && sel_core;
        pcl_write     = wr_core && (offset == ADDR_PROG_COUNTER_LOW[6:0]);
        branch        = is_jump || pcl_write;
        // Entry waits out a branch so its target is not lost
        take_int      = !branch && interrupt_control_ff[INTERRUPT_CONTROL_GIE] && int_lvl_ff;
        gpr_rd_en     = ph_two && sel_gpr;
        gpr_wr_en     = ph_four && wr_file && sel_gpr;
        branch_target = is_jump ? {prog_counter_high_latch_ff[4:3], ir_ff[10:0]}
                                : {prog_counter_high_latch_ff, result};
    end

    // General purpose RAM
    gpr_ram u_gpr (
        .clk_sys (clk_sys),
        .reset   (reset),
        .clk_en  (clk_en),
        .rd_en   (gpr_rd_en),
        .wr_en   (gpr_wr_en),
        .idx     (gpr_idx),
        .wr_data (result),
        .rd_data (gpr_rdata)
    );

    // Fetch side: address out, word captured
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pc_ff          <= RESET_VECTOR;
            fetch_addr_ff  <= '0;
            fetch_buf_ff   <= '0;
            fetch_valid_ff <= 1'b0;
        end else if (clk_en) begin
            if (ph_one) begin
                // Upper counter bits ignored: only 1K words exist
                fetch_addr_ff <= pc_ff[PM_AW-1:0];
                pc_ff         <= pc_ff + PC_STEP;
            end
            if (ph_four) begin
                fetch_buf_ff   <= prog_data;
                // Word fetched behind a branch is thrown away
                fetch_valid_ff <= !(branch || take_int);
                if (take_int) begin
                    pc_ff <= INT_VECTOR;
                end else if (branch) begin
                    pc_ff <= branch_target;
                end
            end
        end
    end

    // Execute side: instruction register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ir_ff         <= '0;
            exec_valid_ff <= 1'b0;
        end else if (clk_en && ph_one) begin
            ir_ff         <= fetch_buf_ff;
            exec_valid_ff <= fetch_valid_ff;
        end
    end

    // Operand latch
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            operand_ff <= '0;
        end else if (clk_en && ph_three) begin
            operand_ff <= operand_now;
        end
    end

    // Peripheral register bus, separate from the program bus
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            per_req_ff <= '0;
        end else if (clk_en) begin
            per_req_ff.re <= ph_two && is_from_file && sel_per;
            per_req_ff.we <= ph_three && wr_file && sel_per;
            if (ph_two || ph_three) begin
                per_req_ff.addr  <= full_addr;
                per_req_ff.wdata <= is_to_file ? acc_ff : operand_now;
            end
        end
    end

    // Accumulator
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            acc_ff <= ACC_RESET;
        end else if (clk_en && ph_four && wr_acc) begin
            acc_ff <= is_literal ? ir_ff[7:0] : result;
        end
    end

    // Status: power flags kept, zero flag from moves out of a file
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_ff <= STATUS_RESET;
        end else if (clk_en && ph_four) begin
            if (wr_core && (offset == ADDR_CORE_STATUS_FLAGS[6:0])) begin
                status_ff <= {result[7:5], status_ff[4:3], result[2:0]};
            end else if (is_from_file) begin
                status_ff[STAT_Z] <= (result == 8'h00);
            end
        end
    end

    // Pointer and high counter latch
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fsr_ff    <= FSR_RESET;
            prog_counter_high_latch_ff <= PROG_COUNTER_HIGH_LATCH_RESET;
        end else if (clk_en && ph_four && wr_core) begin
            if (offset == ADDR_INDIRECT_POINTER[6:0]) begin
                fsr_ff <= result;
            end
            if (offset == ADDR_PROG_COUNTER_HIGH_LATCH[6:0]) begin
                prog_counter_high_latch_ff <= result[4:0];
            end
        end
    end

    // Interrupt control: entry masks further entries
    // Hardware clear of the enable outranks a same-cycle write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            interrupt_control_ff <= INTERRUPT_CONTROL_RESET;
        end else if (clk_en && ph_four) begin
            if (wr_core && (offset == ADDR_INTERRUPT_CONTROL[6:0])) begin
                interrupt_control_ff <= result;
            end
            if (take_int) begin
                interrupt_control_ff[INTERRUPT_CONTROL_GIE] <= 1'b0;
            end
        end
    end

    assign prog_addr = fetch_addr_ff;
    assign per_req   = per_req_ff;
    assign acc_value = acc_ff;
    assign pc_value  = pc_ff;
endmodule
`default_nettype wire

// ### tb/core_clock_pipeline_memmap_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module core_clock_pipeline_memmap_assertions (
    // Clock, reset, enable
    input wire logic                       clk_sys,
    input wire logic                       reset,
    input wire logic                       clk_en,
    input wire logic                       int_req_pin,
    // Buses
    input wire logic [core_pkg::PM_AW-1:0] prog_addr,
    input wire logic [core_pkg::IW-1:0]    prog_data,
    input wire core_pkg::data_req_t        per_req,
    input wire logic [core_pkg::DW-1:0]    per_rdata,
    // State
    input wire logic [3:0]                 phase_vec,
    input wire logic                       instr_rate_out,
    input wire logic [core_pkg::DW-1:0]    acc_value,
    input wire logic [core_pkg::PC_W-1:0]  pc_value
);
    import core_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    sequence s_en4;
        clk_en [*4];
    endsequence
    a_phase_onehot: assert property (!$past(reset) |-> $onehot(phase_vec))
        else $error("phase vector not one-hot");
    a_phase_order: assert property (
        clk_en && |phase_vec |=> phase_vec == $past({phase_vec[2:0], phase_vec[3]}))
        else $error("phase order broken");
    a_four_phase: assert property ((phase_vec == 4'h1) ##0 s_en4 |=> phase_vec == 4'h1)
        else $error("instruction cycle not four phases");
    a_freeze_all: assert property (
        !clk_en |=> $stable(phase_vec) && $stable(pc_value) && $stable(acc_value))
        else $error("state moved while disabled");
    a_rate_out: assert property (
        |phase_vec |-> instr_rate_out == (phase_vec[0] || phase_vec[1]))
        else $error("rate output wrong for phase");
    a_pc_step: assert property (clk_en && phase_vec[0] |=>
        pc_value == $past(pc_value) + 13'h1 && prog_addr == $past(pc_value[9:0]))
        else $error("counter or fetch address wrong after phase one");
    a_addr_hold: assert property (clk_en && !phase_vec[0] |=> $stable(prog_addr))
        else $error("fetch address moved outside phase one");
    a_acc_write: assert property (!phase_vec[3] |=> $stable(acc_value))
        else $error("accumulator written outside phase four");
    a_read_phase: assert property (per_req.re |-> phase_vec[2] && !per_req.we)
        else $error("read strobe outside phase three");
    a_write_once: assert property (
        per_req.we && clk_en |-> phase_vec[3] && !per_req.re ##1 !per_req.we)
        else $error("write strobe wrong phase or length");
    a_peri_decode: assert property (
        per_req.re || per_req.we |-> per_req.addr[6:0] inside {7'h01, 7'h05, 7'h06, 7'h08, 7'h09})
        else $error("peripheral request to a non-peripheral address");
endmodule
bind core_clock_pipeline_memmap core_clock_pipeline_memmap_assertions
    core_clock_pipeline_memmap_assertions_inst (.clk_sys(clk_sys), .reset(reset),
    .clk_en(clk_en), .int_req_pin(int_req_pin), .prog_addr(prog_addr),
    .prog_data(prog_data), .per_req(per_req), .per_rdata(per_rdata), .phase_vec(phase_vec),
    .instr_rate_out(instr_rate_out), .acc_value(acc_value), .pc_value(pc_value));
`default_nettype wire

// ### tb/prog_data_partner.sv
`timescale 1ns/10ps
`default_nettype none
module prog_data_partner (
    // Clock, enable
    input  wire logic                       clk_sys,
    input  wire logic                       clk_en,
    // Program bus
    input  wire logic [core_pkg::PM_AW-1:0] prog_addr,
    output logic [core_pkg::IW-1:0]         prog_data,
    // Peripheral bus
    input  wire core_pkg::data_req_t        per_req,
    output logic [core_pkg::DW-1:0]         per_rdata
);
    import core_pkg::*;
    logic [IW-1:0] rom [1024];
    logic [DW-1:0] regs [256];
    logic [DW-1:0] last_ff;
    // Own path, so fetches never wait on data traffic
    assign prog_data = rom[prog_addr];
    // Unselected bus shows inverted last value so a stale read cannot match
    assign per_rdata = per_req.re ? regs[per_req.addr] : ~last_ff;
    always @(posedge clk_sys) begin
        if (clk_en && per_req.re) begin
            last_ff <= regs[per_req.addr];
        end
        if (clk_en && per_req.we) begin
            regs[per_req.addr] <= per_req.wdata;
        end
    end
endmodule
`default_nettype wire

// ### tb/test_core_clock_pipeline_memmap.sv
`timescale 1ns/10ps
`default_nettype none
module test_core_clock_pipeline_memmap;
    import core_pkg::*;
    typedef struct packed {
        logic [IW-1:0] ins;
        logic [DW-1:0] acc;
    } row_t;
    localparam int NROWS = 16;
    // Program word and accumulator once that word has executed
    localparam row_t ROWS [NROWS] = '{
        '{14'h305a, 8'h5a}, '{14'h008c, 8'h5a}, '{14'h3000, 8'h00}, '{14'h080c, 8'h5a},
        '{14'h0085, 8'h5a}, '{14'h0806, 8'hc3}, '{14'h0087, 8'hc3}, '{14'h0807, 8'h00},
        '{14'h300c, 8'h0c}, '{14'h0084, 8'h0c}, '{14'h0800, 8'h5a}, '{14'h3020, 8'h20},
        '{14'h0083, 8'h20}, '{14'h080c, 8'h5a}, '{14'h0085, 8'h5a}, '{14'h2420, 8'h5a}
    };
    logic             clk_sys;
    logic             reset;
    logic             clk_en;
    logic             int_req_pin;
    logic [PM_AW-1:0] prog_addr;
    logic [IW-1:0]    prog_data;
    data_req_t        per_req;
    logic [DW-1:0]    per_rdata;
    logic [3:0]       phase_vec;
    logic             instr_rate_out;
    logic [DW-1:0]    acc_value;
    logic [PC_W-1:0]  pc_value;
    int               err_count = 0;
    int               checked = 0;

    core_clock_pipeline_memmap core_clock_pipeline_memmap_inst (
        .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .int_req_pin(int_req_pin),
        .prog_addr(prog_addr), .prog_data(prog_data), .per_req(per_req),
        .per_rdata(per_rdata), .phase_vec(phase_vec), .instr_rate_out(instr_rate_out),
        .acc_value(acc_value), .pc_value(pc_value));
    prog_data_partner prog_data_partner_inst (
        .clk_sys(clk_sys), .clk_en(clk_en), .prog_addr(prog_addr),
        .prog_data(prog_data), .per_req(per_req), .per_rdata(per_rdata));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Next phase one, sampled mid-cycle so the launching edge has settled
    task automatic next_cycle();
        for (int n = 0; n < 40; n++) begin
            @(negedge clk_sys);
            if (phase_vec === 4'h1) return;
        end
        err_count++;
        test_done();
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        int_req_pin = 1'b0;
        for (int i = 0; i < 1024; i++) begin
            prog_data_partner_inst.rom[i] = (i < NROWS) ? ROWS[i].ins : 14'h0000;
        end
        for (int i = 0; i < 256; i++) begin
            prog_data_partner_inst.regs[i] = (i == 6) ? 8'hc3 : 8'h00;
        end
        // Flushed slot, jump target, then enable interrupts
        prog_data_partner_inst.rom[16] = 14'h3011;
        prog_data_partner_inst.rom[32] = 14'h3077;
        prog_data_partner_inst.rom[33] = 14'h3080;
        prog_data_partner_inst.rom[34] = 14'h008b;
        repeat (8) @(negedge clk_sys);
        reset = 1'b0;
        next_cycle();
        next_cycle();
        for (int i = 0; i < NROWS; i++) begin
            next_cycle();
            check("acc_value", 16'(acc_value), 16'(ROWS[i].acc));
            if (i < NROWS - 1) begin
                check("pc_value", 16'(pc_value), 16'(i + 2));
            end
        end
        check("port_a_pins", 16'(prog_data_partner_inst.regs[8'h05]), 16'h5a);
        check("port_a_direction", 16'(prog_data_partner_inst.regs[8'h85]), 16'h5a);
        $display("test straight_line done");
        next_cycle();
        check("flushed acc", 16'(acc_value), 16'h5a);
        check("wrapped prog_addr", 16'(prog_addr), 16'h20);
        check("pc_value", 16'(pc_value), 16'h421);
        next_cycle();
        check("target acc", 16'(acc_value), 16'h77);
        $display("test jump done");
        int_req_pin = 1'b1;
        for (int n = 0; n < 60 && prog_addr !== 10'h004; n++) @(negedge clk_sys);
        check("vector prog_addr", 16'(prog_addr), 16'h4);
        int_req_pin = 1'b0;
        $display("test interrupt done");
        next_cycle();
        clk_en = 1'b0;
        repeat (3) @(negedge clk_sys);
        check("frozen phase", 16'(phase_vec), 16'h1);
        clk_en = 1'b1;
        @(negedge clk_sys);
        check("resumed phase", 16'(phase_vec), 16'h2);
        $display("test freeze done");
        // Second program: branch by writing the counter's low byte
        prog_data_partner_inst.rom[0] = 14'h3005;
        prog_data_partner_inst.rom[1] = 14'h008a;
        prog_data_partner_inst.rom[2] = 14'h3040;
        prog_data_partner_inst.rom[3] = 14'h0082;
        prog_data_partner_inst.rom[4] = 14'h3011;
        prog_data_partner_inst.rom[320] = 14'h3099;
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("reset phase", 16'(phase_vec), 16'h0);
        check("reset pc", 16'(pc_value), 16'h0);
        check("reset acc", 16'(acc_value), 16'h0);
        reset = 1'b0;
        @(negedge clk_sys);
        check("first phase", 16'(phase_vec), 16'h1);
        check("rate out", 16'(instr_rate_out), 16'h1);
        @(negedge clk_sys);
        check("first fetch", 16'(prog_addr), 16'h0);
        check("pc after fetch", 16'(pc_value), 16'h1);
        $display("test reset done");
        repeat (5) next_cycle();
        check("pcl branch pc", 16'(pc_value), 16'h540);
        next_cycle();
        check("pcl flushed acc", 16'(acc_value), 16'h40);
        next_cycle();
        check("pcl target acc", 16'(acc_value), 16'h99);
        check("pcl wrapped fetch", 16'(prog_addr), 16'h141);
        $display("test pcl done");
        test_done();
    end
endmodule
`default_nettype wire
